// ===== core/ssm_ctrl.sv
// mode select, lockout and option state for the stereo synthesizer
//
// Notes on behaviour
// - ten external lines; basic mode lines obey the pulse/continuous setting
// - standby lamp lights only while some external line is active
// - standby becomes active when all lines drop or on lockout entry
// - mode button under external hold only changes the standby mode
// - left, right or bypass button cancels auto and selects that mode
// - lockout lets panel buttons win over the basic mode lines; standby goes active
// - comb bandwidth wide (five bands) or narrow (fifteen bands) held
// - auto polarity on: polarity_corrected_lamp input flips right channel and lights lamp
// - noise reduction defeat disables expander; lamp only while expanding
// - auto: audio on one channel only, synthesize from that channel
// - auto, both channels: centre mono selects left if enabled, else bypass
// - pulse automation: line pulse acts as the matching button press
// - continuous automation: left, right or bypass line holds mode; release returns to standby
// - lockout entry switches to standby only if a standby lamp is lit
// - under lockout buttons pick any mode and recognition keeps running
// - lockout button toggles on and off
// - exactly one active lamp shows the actual mode
// - two or more basic lines at once force auto mode
// - lockout never blocks remote panel buttons
`timescale 1ns/100ps
module ssm_ctrl #(
  parameter int unsigned DEB_CYCLES = ssm_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        rstn_in,
  // panel buttons, one-cycle presses
  input  wire logic [ssm_pkg::NUM_BTN-1:0] local_btn_in,
  input  wire logic [ssm_pkg::NUM_BTN-1:0] remote_btn_in,
  // isolated automation lines
  input  wire logic [ssm_pkg::NUM_EXT-1:0] ext_ctl_in,
  // rear panel switches
  input  wire logic                        pulse_mode_in,
  input  wire logic                        center_and_single_recognition_in,
  // power-up straps
  input  wire logic [1:0]                  strap_mode_in,
  input  wire logic                        strap_pol_off_in,
  input  wire logic                        strap_comb_wide_in,
  input  wire logic                        strap_nr_defeat_in,
  // detector results
  input  wire logic                        left_audio_in,
  input  wire logic                        right_audio_in,
  input  wire logic                        center_mono_in,
  input  wire logic                        pol_polarity_corrected_lamp_in,
  input  wire logic                        expand_req_in,
  // mode lamps
  output logic [3:0]                       active_lamp_out,
  output logic [3:0]                       standby_lamp_out,
  output logic                             lockout_lamp_out,
  output logic                             auto_error_out,
  // option state and lamps
  output logic                             comb_wide_out,
  output logic                             comb_narrow_out,
  output logic                             auto_pol_on_out,
  output logic                             flip_right_out,
  output logic                             polarity_corrected_lamp_out,
  output logic                             nr_operate_out,
  output logic                             expansion_lamp_out,
  // processing path
  output logic                             synth_enable_out,
  output logic                             synth_from_right_out
);
  typedef struct packed {
    logic              init_done;
    ssm_pkg::ssm_mode_t active;
    ssm_pkg::ssm_mode_t standby;
    ssm_pkg::ssm_mode_t auto_dec;
    logic              ext_any;
    logic              lockout;
    logic              auto_err;
    logic              comb_wide;
    logic              pol_on;
    logic              nr_defeat;
    logic [3:0]        act_lamp;
    logic [3:0]        sby_lamp;
    logic              flip_right;
    logic              expand_lamp;
    logic              synth_en;
    logic              synth_right;
  } ssm_state_t;

  localparam logic [3:0] LAMP_NONE = 4'h0;
  localparam logic [3:0] ONE4      = 4'h1;
  localparam logic [ssm_pkg::NUM_EXT-1:0] BASIC_MASK = 10'h00f;

  ssm_ext_if ext ();

  ssm_state_t s_reg;
  ssm_state_t s_next;

  ssm_in_filter #(
    .DEB_CYCLES (DEB_CYCLES)
  ) u_filter (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .raw_in     (ext_ctl_in),
    .ext        (ext.src)
  );

  // priority left, right, bypass, auto over a set of basic hits
  function automatic ssm_pkg::ssm_cmd_t mode_cmd(input logic [3:0] hit);
    ssm_pkg::ssm_cmd_t c;
    c.valid = |hit;
    c.mode  = ssm_pkg::MODE_AUTO;
    if (hit[ssm_pkg::EXT_LEFT]) begin
      c.mode = ssm_pkg::MODE_LEFT;
    end else if (hit[ssm_pkg::EXT_RIGHT]) begin
      c.mode = ssm_pkg::MODE_RIGHT;
    end else if (hit[ssm_pkg::EXT_BYPASS]) begin
      c.mode = ssm_pkg::MODE_BYPASS;
    end
    return c;
  endfunction : mode_cmd

  function automatic logic [3:0] lamp_of(input ssm_pkg::ssm_mode_t m);
    return ONE4 << m;
  endfunction : lamp_of

  logic [ssm_pkg::NUM_BTN-1:0] btn;
  logic [ssm_pkg::NUM_EXT-1:0] ext_eff;
  logic [ssm_pkg::NUM_EXT-1:0] ext_cmd;
  logic [3:0]                  basic;
  logic                        any_act;
  ssm_pkg::ssm_cmd_t           bcmd;
  ssm_pkg::ssm_cmd_t           pcmd;
  ssm_pkg::ssm_cmd_t           ccmd;
  ssm_pkg::ssm_mode_t          proc_mode;

  always_comb begin
    s_next  = s_reg;
    // remote presses merge here, so lockout can never mask them
    btn     = local_btn_in | remote_btn_in;
    ext_eff = ext.level;
    ext_cmd = ext.rise;
    basic   = LAMP_NONE;
    any_act = 1'b0;
    bcmd    = '0;
    pcmd    = '0;
    ccmd    = '0;
    if (!s_reg.init_done) begin
      // straps are caught on the first edge after reset release
      s_next.init_done = 1'b1;
      s_next.active    = ssm_pkg::ssm_mode_t'(strap_mode_in);
      s_next.standby   = ssm_pkg::ssm_mode_t'(strap_mode_in);
      s_next.pol_on    = !strap_pol_off_in;
      s_next.comb_wide = strap_comb_wide_in;
      s_next.nr_defeat = strap_nr_defeat_in;
    end else begin
      if (btn[ssm_pkg::BTN_LOCK]) begin
        s_next.lockout = !s_reg.lockout;
        if (!s_reg.lockout && s_reg.ext_any) begin
          s_next.active = s_reg.standby;
        end
      end
      // lockout hides only the four basic mode lines
      if (s_next.lockout) begin
        ext_eff = ext.level & ~BASIC_MASK;
        ext_cmd = ext.rise & ~BASIC_MASK;
      end
      basic   = ext_eff[ssm_pkg::NUM_BASIC-1:0];
      any_act = |ext_eff;
      s_next.ext_any = any_act;

      bcmd = mode_cmd(btn[ssm_pkg::NUM_BASIC-1:0]);
      if (bcmd.valid) begin
        s_next.standby = bcmd.mode;
        if (!any_act) begin
          s_next.active = bcmd.mode;
        end
      end

      if (pulse_mode_in) begin
        // a debounced rising edge stands in for a button press
        pcmd = mode_cmd(ext_cmd[ssm_pkg::NUM_BASIC-1:0]);
        if (pcmd.valid) begin
          s_next.active  = pcmd.mode;
          s_next.standby = pcmd.mode;
        end
      end else begin
        // auto line selects no mode as a continuous level
        ccmd = mode_cmd(basic & ~(ONE4 << ssm_pkg::EXT_AUTO));
        if (ccmd.valid) begin
          s_next.active = ccmd.mode;
        end
      end

      s_next.auto_err = (basic & (basic - ONE4)) != LAMP_NONE;
      if (s_next.auto_err) begin
        s_next.active = ssm_pkg::MODE_AUTO;
      end
      if (!any_act) begin
        s_next.active = s_next.standby;
      end

      // option lines are edges in either automation setting
      if (btn[ssm_pkg::EXT_WIDE] || ext_cmd[ssm_pkg::EXT_WIDE]) begin
        s_next.comb_wide = 1'b1;
      end else if (btn[ssm_pkg::EXT_NARROW]
                   || ext_cmd[ssm_pkg::EXT_NARROW]) begin
        s_next.comb_wide = 1'b0;
      end
      if (btn[ssm_pkg::EXT_POL_ON] || ext_cmd[ssm_pkg::EXT_POL_ON]) begin
        s_next.pol_on = 1'b1;
      end else if (btn[ssm_pkg::EXT_POL_OFF]
                   || ext_cmd[ssm_pkg::EXT_POL_OFF]) begin
        s_next.pol_on = 1'b0;
      end
      if (btn[ssm_pkg::EXT_NR_DEF] || ext_cmd[ssm_pkg::EXT_NR_DEF]) begin
        s_next.nr_defeat = 1'b1;
      end else if (btn[ssm_pkg::EXT_NR_OP]
                   || ext_cmd[ssm_pkg::EXT_NR_OP]) begin
        s_next.nr_defeat = 1'b0;
      end

      // recognition runs only in auto and freezes on silence
      if (s_next.active == ssm_pkg::MODE_AUTO) begin
        if (left_audio_in && !right_audio_in) begin
          s_next.auto_dec = ssm_pkg::MODE_LEFT;
        end else if (right_audio_in && !left_audio_in) begin
          s_next.auto_dec = ssm_pkg::MODE_RIGHT;
        end else if (left_audio_in && right_audio_in) begin
          if (center_and_single_recognition_in && center_mono_in) begin
            s_next.auto_dec = ssm_pkg::MODE_LEFT;
          end else begin
            s_next.auto_dec = ssm_pkg::MODE_BYPASS;
          end
        end else begin
          s_next.auto_dec = s_reg.auto_dec;
        end
      end
    end

    proc_mode = (s_next.active == ssm_pkg::MODE_AUTO) ?
                s_next.auto_dec : s_next.active;
    s_next.synth_en    = proc_mode != ssm_pkg::MODE_BYPASS;
    s_next.synth_right = proc_mode == ssm_pkg::MODE_RIGHT;
    s_next.act_lamp    = lamp_of(s_next.active);
    s_next.sby_lamp    = any_act ? lamp_of(s_next.standby)
                                 : LAMP_NONE;
    s_next.flip_right  = s_next.pol_on && pol_polarity_corrected_lamp_in;
    // expander only acts on the synthesized path
    s_next.expand_lamp = !s_next.nr_defeat && expand_req_in
                         && s_next.synth_en;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg             <= '0;
      s_reg.active      <= ssm_pkg::RST_MODE;
      s_reg.standby     <= ssm_pkg::RST_MODE;
      s_reg.auto_dec    <= ssm_pkg::MODE_BYPASS;
      s_reg.pol_on      <= ssm_pkg::RST_POL_ON;
      s_reg.comb_wide   <= ssm_pkg::RST_COMB_WIDE;
      s_reg.nr_defeat   <= ssm_pkg::RST_NR_DEFEAT;
      s_reg.act_lamp    <= ONE4 << ssm_pkg::RST_MODE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign active_lamp_out             = s_reg.act_lamp;
  assign standby_lamp_out            = s_reg.sby_lamp;
  assign lockout_lamp_out            = s_reg.lockout;
  assign auto_error_out              = s_reg.auto_err;
  assign comb_wide_out               = s_reg.comb_wide;
  assign comb_narrow_out             = !s_reg.comb_wide;
  assign auto_pol_on_out             = s_reg.pol_on;
  assign flip_right_out              = s_reg.flip_right;
  assign polarity_corrected_lamp_out = s_reg.flip_right;
  assign nr_operate_out              = !s_reg.nr_defeat;
  assign expansion_lamp_out          = s_reg.expand_lamp;
  assign synth_enable_out            = s_reg.synth_en;
  assign synth_from_right_out        = s_reg.synth_right;
endmodule : ssm_ctrl

// ===== core/ssm_pkg.sv
// shared constants and types for the stereo mode select controller
package ssm_pkg;
  typedef enum logic [1:0] {
    MODE_LEFT,
    MODE_RIGHT,
    MODE_BYPASS,
    MODE_AUTO
  } ssm_mode_t;

  typedef struct packed {
    logic      valid;
    ssm_mode_t mode;
  } ssm_cmd_t;

  localparam int NUM_EXT = 10;
  localparam int NUM_BTN = 11;

  // external line positions; the first four are the basic mode lines
  localparam int EXT_LEFT   = 0;
  localparam int EXT_RIGHT  = 1;
  localparam int EXT_BYPASS = 2;
  localparam int EXT_AUTO   = 3;
  localparam int EXT_WIDE   = 4;
  localparam int EXT_NARROW = 5;
  localparam int EXT_POL_ON = 6;
  localparam int EXT_POL_OFF = 7;
  localparam int EXT_NR_OP  = 8;
  localparam int EXT_NR_DEF = 9;
  localparam int NUM_BASIC  = 4;

  // panel button positions share the layout, plus lockout
  localparam int BTN_LOCK = 10;

  // power-up values before the straps are caught
  localparam ssm_mode_t RST_MODE = MODE_AUTO;
  localparam logic RST_POL_ON    = 1'b1;
  localparam logic RST_COMB_WIDE = 1'b0;
  localparam logic RST_NR_DEFEAT = 1'b0;

  // input filter timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int DEBOUNCE_MS = 5;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int DEB_W       = 18;
endpackage : ssm_pkg

// ===== core/ssm_ext_if.sv
// filtered external control lines passed from the filter to the controller
`timescale 1ns/100ps
interface ssm_ext_if;
  logic [ssm_pkg::NUM_EXT-1:0] level;
  logic [ssm_pkg::NUM_EXT-1:0] rise;

  modport src (output level, output rise);
  modport dst (input  level, input  rise);
endinterface : ssm_ext_if

// ===== core/ssm_in_filter.sv
// synchroniser and debounce filter for the isolated external control lines
`timescale 1ns/100ps
module ssm_in_filter #(
  parameter int unsigned DEB_CYCLES = ssm_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input  wire logic                        sys_clk_in,
  input  wire logic                        rstn_in,
  // raw lines
  input  wire logic [ssm_pkg::NUM_EXT-1:0] raw_in,
  // filtered result
  ssm_ext_if.src                           ext
);
  localparam logic [ssm_pkg::DEB_W-1:0] CNT_ONE = 18'h00001;
  localparam logic [ssm_pkg::DEB_W-1:0] CNT_END =
    ssm_pkg::DEB_W'(DEB_CYCLES - 1);

  typedef struct packed {
    logic [ssm_pkg::NUM_EXT-1:0]                    meta;
    logic [ssm_pkg::NUM_EXT-1:0]                    sync;
    logic [ssm_pkg::NUM_EXT-1:0]                    level;
    logic [ssm_pkg::NUM_EXT-1:0]                    rise;
    logic [ssm_pkg::NUM_EXT-1:0][ssm_pkg::DEB_W-1:0] cnt;
  } ssm_flt_t;

  ssm_flt_t s_reg;
  ssm_flt_t s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.meta = raw_in;
    s_next.sync = s_reg.meta;
    s_next.rise = '0;
    for (int i = 0; i < ssm_pkg::NUM_EXT; i++) begin
      // a line must disagree for the full window before the level moves
      if (s_reg.sync[i] == s_reg.level[i]) begin
        s_next.cnt[i] = '0;
      end else if (s_reg.cnt[i] >= CNT_END) begin
        s_next.cnt[i]   = '0;
        s_next.level[i] = s_reg.sync[i];
        s_next.rise[i]  = s_reg.sync[i];
      end else begin
        s_next.cnt[i] = s_reg.cnt[i] + CNT_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ext.level = s_reg.level;
  assign ext.rise  = s_reg.rise;
endmodule : ssm_in_filter

// ===== bench/ssm_ctrl_monitor.sv
// property checker for the mode select controller ports
`timescale 1ns/100ps
module ssm_ctrl_monitor #(
  parameter int unsigned DEB_CYCLES = 4
) (
  // clock, reset, commands
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic [10:0] local_btn_in,
  input wire logic [10:0] remote_btn_in,
  // detectors and switches
  input wire logic        left_audio_in,
  input wire logic        right_audio_in,
  input wire logic        center_mono_in,
  input wire logic        center_and_single_recognition_in,
  input wire logic        expand_req_in,
  // watched outputs
  input wire logic [3:0]  active_lamp_out,
  input wire logic [3:0]  standby_lamp_out,
  input wire logic        lockout_lamp_out,
  input wire logic        auto_error_out,
  input wire logic        comb_wide_out,
  input wire logic        comb_narrow_out,
  input wire logic        flip_right_out,
  input wire logic        polarity_corrected_lamp_out,
  input wire logic        expansion_lamp_out,
  input wire logic        synth_enable_out,
  input wire logic        synth_from_right_out
);
  logic [10:0] btn;
  logic        in_auto;
  logic        both;
  assign btn     = local_btn_in | remote_btn_in;
  assign in_auto = active_lamp_out == 4'h8;
  assign both    = left_audio_in && right_audio_in;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  a_active_one_hot: assert property ($onehot(active_lamp_out))
    else $error("active lamps not one-hot");
  a_standby_lamp_form: assert property ($onehot0(standby_lamp_out))
    else $error("more than one standby lamp");
  a_comb_pair: assert property (comb_wide_out ^ comb_narrow_out)
    else $error("comb width lamps not complementary");
  a_pol_lamp_match: assert property (
    polarity_corrected_lamp_out == flip_right_out)
    else $error("polarity lamp differs from flip");
  a_expand_cause: assert property (expansion_lamp_out |->
    $past(expand_req_in) && synth_enable_out)
    else $error("expansion lamp without cause");
  a_lock_toggle: assert property (btn[10] |=>
    lockout_lamp_out != $past(lockout_lamp_out))
    else $error("lockout did not toggle");
  a_left_press: assert property (
    btn[0] && !btn[10] && standby_lamp_out == 4'h0 |=>
    active_lamp_out == 4'h1 && synth_enable_out && !synth_from_right_out)
    else $error("left press not applied");
  a_error_auto: assert property (auto_error_out |-> in_auto)
    else $error("automation error without auto");
  a_auto_one_side: assert property (
    (in_auto && left_audio_in && !right_audio_in) [*3] |->
    synth_enable_out && !synth_from_right_out)
    else $error("left-only audio not synthesized");
  a_auto_mono: assert property ((in_auto && both &&
    center_mono_in && center_and_single_recognition_in) [*3] |->
    synth_enable_out && !synth_from_right_out)
    else $error("centre mono not synthesized from left");
  a_auto_stereo: assert property (
    (in_auto && both && !center_and_single_recognition_in) [*3] |->
    !synth_enable_out)
    else $error("stereo audio not bypassed");
  c_lockout: cover property ($rose(lockout_lamp_out));
  c_error: cover property ($rose(auto_error_out));
  c_standby: cover property (standby_lamp_out != 4'h0);
endmodule : ssm_ctrl_monitor

bind ssm_ctrl ssm_ctrl_monitor #(.DEB_CYCLES(DEB_CYCLES)) mon (
  .sys_clk_in, .rstn_in, .local_btn_in, .remote_btn_in,
  .left_audio_in, .right_audio_in, .center_mono_in,
  .center_and_single_recognition_in, .expand_req_in,
  .active_lamp_out, .standby_lamp_out, .lockout_lamp_out,
  .auto_error_out, .comb_wide_out, .comb_narrow_out,
  .flip_right_out, .polarity_corrected_lamp_out,
  .expansion_lamp_out, .synth_enable_out, .synth_from_right_out);

// ===== bench/ssm_auto_model.sv
// behavioural automation system driving the isolated control lines
`timescale 1ns/100ps
module ssm_auto_model (
  // clock
  input wire logic  sys_clk_in,
  // control lines
  output logic [9:0] ext_out
);
  initial ext_out = 10'h000;
  task automatic hold(input logic [9:0] v);
    @(posedge sys_clk_in);
    ext_out <= v;
  endtask : hold
  // a bounce ahead of the real pulse, as contacts give
  task automatic pulse(input int b, input int len);
    @(posedge sys_clk_in);
    ext_out[b] <= 1'b1;
    @(posedge sys_clk_in);
    ext_out[b] <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    ext_out[b] <= 1'b1;
    repeat (len) @(posedge sys_clk_in);
    ext_out[b] <= 1'b0;
  endtask : pulse
endmodule : ssm_auto_model

// ===== bench/stereo_mode_select_controller_test.sv
// self-checking bench for the mode select controller
`timescale 1ns/100ps
module stereo_mode_select_controller_test;
  logic clk, rstn, pmode, recog, la, ra, mono, inv, expq;
  logic [10:0] lbtn, rbtn;
  logic [9:0]  ext;
  logic [3:0]  act, stby;
  logic lock, err, wide, narrow, pol, flip, polc, nr, expl, syn, synr;
  logic [1:0]  e_mode;
  logic [1:0]  smode;
  logic        spoff, swide, snrd;
  logic        e_wide, e_pol, e_nr, e_lock;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  ssm_auto_model auto_sys (.sys_clk_in(clk), .ext_out(ext));
  ssm_ctrl #(.DEB_CYCLES(4)) DUT (.sys_clk_in(clk), .rstn_in(rstn),
    .local_btn_in(lbtn), .remote_btn_in(rbtn), .ext_ctl_in(ext),
    .pulse_mode_in(pmode), .center_and_single_recognition_in(recog),
    .strap_mode_in(smode), .strap_pol_off_in(spoff),
    .strap_comb_wide_in(swide), .strap_nr_defeat_in(snrd),
    .left_audio_in(la), .right_audio_in(ra), .center_mono_in(mono),
    .pol_polarity_corrected_lamp_in(inv), .expand_req_in(expq),
    .active_lamp_out(act), .standby_lamp_out(stby),
    .lockout_lamp_out(lock), .auto_error_out(err),
    .comb_wide_out(wide), .comb_narrow_out(narrow),
    .auto_pol_on_out(pol), .flip_right_out(flip),
    .polarity_corrected_lamp_out(polc), .nr_operate_out(nr),
    .expansion_lamp_out(expl), .synth_enable_out(syn),
    .synth_from_right_out(synr));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // the last mode press is the standby mode, so it also is what returns
  function automatic void model(input logic [10:0] b);
    if (b[0]) e_mode = 2'h0;
    else if (b[1]) e_mode = 2'h1;
    else if (b[2]) e_mode = 2'h2;
    else if (b[3]) e_mode = 2'h3;
    if (b[4]) e_wide = 1'b1;
    else if (b[5]) e_wide = 1'b0;
    if (b[6]) e_pol = 1'b1;
    else if (b[7]) e_pol = 1'b0;
    if (b[9]) e_nr = 1'b0;
    else if (b[8]) e_nr = 1'b1;
    if (b[10]) e_lock = !e_lock;
  endfunction : model
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic press(input logic [10:0] b, input logic rem);
    @(posedge clk);
    if (rem) rbtn <= b;
    else lbtn <= b;
    @(posedge clk);
    lbtn <= 11'h000;
    rbtn <= 11'h000;
    #1;
    model(b);
  endtask : press
  task automatic chk_all;
    chk({act, wide, pol, nr, lock}, {4'h1 << e_mode, e_wide, e_pol, e_nr,
      e_lock});
  endtask : chk_all
  initial begin
    {rstn, pmode, recog, la, ra, mono, inv, expq} = 8'h00;
    lbtn = 11'h000;
    rbtn = 11'h000;
    void'($urandom(26));
    // straps are drawn at random so the power-up load is exercised
    {smode, spoff, swide, snrd} = 5'($urandom);
    {e_mode, e_wide, e_pol, e_nr, e_lock} =
      {smode, swide, !spoff, !snrd, 1'b0};
    tick(8);
    chk({act, stby, lock, err, narrow, pol, nr, syn}, 16'h200e);
    rstn <= 1'b1;
    tick(3);
    chk_all();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      press(11'h001 << i, i[0]);
      chk_all();
    end
    $display("test mode buttons done");
    for (int i = 0; i < 60; i++) begin
      {la, ra, mono, recog, inv, expq} <= 6'($urandom);
      press(11'($urandom), 1'($urandom));
      chk_all();
    end
    if (e_lock) press(11'h400, 1'b0);
    $display("test random presses done");
    press(11'h004, 1'b0);
    auto_sys.hold(10'h001);
    tick(12);
    chk({act, stby}, 8'h14);
    press(11'h002, 1'b0);
    chk({act, stby}, 8'h12);
    auto_sys.hold(10'h000);
    tick(12);
    chk_all();
    chk(stby, 4'h0);
    auto_sys.hold(10'h003);
    tick(12);
    chk({err, act}, 5'h18);
    auto_sys.hold(10'h000);
    tick(12);
    chk_all();
    $display("test continuous automation done");
    auto_sys.hold(10'h004);
    tick(12);
    chk(act, 4'h4);
    press(11'h400, 1'b0);
    chk_all();
    press(11'h001, 1'b1);
    chk_all();
    press(11'h008, 1'b0);
    chk_all();
    press(11'h400, 1'b0);
    auto_sys.hold(10'h000);
    tick(12);
    chk_all();
    $display("test lockout done");
    pmode <= 1'b1;
    auto_sys.pulse(2, 8);
    tick(12);
    model(11'h004);
    chk_all();
    $display("test pulse automation done");
    pmode <= 1'b0;
    {la, ra, mono, recog, inv, expq} <= 6'b010000;
    press(11'h008, 1'b0);
    tick(4);
    chk({syn, synr}, 2'b11);
    {la, ra, mono, recog} <= 4'b1111;
    tick(4);
    chk({syn, synr}, 2'b10);
    recog <= 1'b0;
    tick(4);
    chk(syn, 1'b0);
    {la, ra} <= 2'b00;
    tick(4);
    chk(syn, 1'b0);
    la <= 1'b1;
    tick(4);
    {la, inv, expq} <= 3'b011;
    press(11'h140, 1'b0);
    tick(4);
    chk({syn, synr, flip, polc, expl}, 5'h17);
    press(11'h200, 1'b0);
    tick(3);
    chk({nr, expl}, 2'b00);
    $display("test auto decision done");
    final_report();
  end
endmodule : stereo_mode_select_controller_test
